// *** tb/aaces_clk_src.sv ***
// audio clock source model: master, bit and frame clocks for the bank
`timescale 1ns/1ns
module aaces_clk_src (
  input var int per_frame,
  input wire logic stretch,
  output logic mclk_pin,
  output logic bclk_pin,
  output logic fclk_pin
);
  int cnt;
  // 400 ns master period: each half spans two samples of the bank clock,
  // which the agreement filter needs; stretch adds one cycle once (slip)
  initial begin
    mclk_pin = 1'b0;
    bclk_pin = 1'b0;
    fclk_pin = 1'b0;
    cnt = 0;
    #25;
    forever begin
      #(stretch ? 300 : 200) mclk_pin = ~mclk_pin;
      if (mclk_pin) begin
        cnt = (cnt + 1 >= per_frame) ? 0 : cnt + 1;
        bclk_pin = cnt[0];
        fclk_pin = (cnt < per_frame / 2);
      end
    end
  end
endmodule

// *** tb/aaces_regs_assertions.sv ***
// concurrent checks on the ports of the clock/error register bank
`timescale 1ns/1ns
module aaces_regs_chk #(
  parameter logic [7:0] REV_ID = 8'h5a
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire aaces_pkg::aaces_fault_t fault_in,
  input wire aaces_pkg::aaces_sysctl_t sys_ctrl,
  input wire logic [3:0] serial_fmt,
  input wire logic [9:0] unmute_level
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  logic rd_flags_q;
  logic [7:0] seen_reg;
  int zero_cnt;
  wire logic rd_flags = reg_rd && reg_addr == 8'h02;
  wire logic wr_flags = reg_wr && reg_addr == 8'h02;
  wire logic [7:0] fault_bits = {1'b0, fault_in.pll_fail, 3'b000,
    fault_in.clip, fault_in.protect, 1'b0};
  ////////////////////////////////////////
  // flags software has seen, less the ones it cleared since
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_flags_q <= 1'b0;
      seen_reg <= 8'h00;
      zero_cnt <= 0;
    end else begin
      rd_flags_q <= rd_flags;
      seen_reg <= (rd_flags_q ? reg_rdata : seen_reg) &
        (wr_flags ? reg_wdata : 8'hff);
      zero_cnt <= (sys_ctrl.hard_unmute && unmute_level == 10'h000) ?
        zero_cnt + 1 : 0;
    end
  end
  ////////////////////////////////////////
  property p_rev_id;
    reg_rd && reg_addr == 8'h01 |=> reg_rdata == REV_ID;
  endproperty
  a_rev_id: assert property (p_rev_id)
    else $error("identification code wrong");
  property p_flag0;
    rd_flags |=> reg_rdata[0] == 1'b0;
  endproperty
  a_flag0: assert property (p_flag0)
    else $error("flag bit 0 set");
  property p_rate_rsv;
    reg_rd && reg_addr == 8'h00 |=> !(reg_rdata[7:5] inside {3'h1, 3'h2})
      && reg_rdata[4:2] != 3'h7;
  endproperty
  a_rate_rsv: assert property (p_rate_rsv)
    else $error("reserved status code shown");
  property p_sys_wr;
    reg_wr && reg_addr == 8'h03 |=> sys_ctrl == {$past(reg_wdata[7]),
      $past(reg_wdata[5]), $past(reg_wdata[1:0])};
  endproperty
  a_sys_wr: assert property (p_sys_wr)
    else $error("system control outputs not written");
  property p_fmt_wr;
    reg_wr && reg_addr == 8'h04 |=> serial_fmt == $past(reg_wdata[3:0]);
  endproperty
  a_fmt_wr: assert property (p_fmt_wr)
    else $error("format output not written");
  property p_sticky;
    rd_flags |=> (reg_rdata & seen_reg) == seen_reg;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without a zero write");
  property p_fault_set;
    fault_bits != 8'h00 ##2 rd_flags |=>
      (reg_rdata & $past(fault_bits, 3)) == $past(fault_bits, 3);
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault input did not set its flag");
  property p_soft_ramp;
    !sys_ctrl.hard_unmute && !$past(sys_ctrl.hard_unmute) &&
      unmute_level != 10'h000 |->
      {1'b0, unmute_level} <= {1'b0, $past(unmute_level)} + 11'h001;
  endproperty
  a_soft_ramp: assert property (p_soft_ramp)
    else $error("soft unmute jumped");
  property p_hard_unmute;
    zero_cnt < 5000;
  endproperty
  a_hard_unmute: assert property (p_hard_unmute)
    else $error("hard unmute did not restore");
  property p_level_max;
    unmute_level <= 10'h200;
  endproperty
  a_level_max: assert property (p_level_max)
    else $error("unmute level above full scale");
endmodule

bind aaces_regs aaces_regs_chk #(.REV_ID(REV_ID)) u_chk (
  .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .fault_in(fault_in), .sys_ctrl(sys_ctrl),
  .serial_fmt(serial_fmt), .unmute_level(unmute_level)
);

// *** tb/tb_top.sv ***
// self-checking bench for the clock/error register bank
`timescale 1ns/1ns
module tb_top;
  logic mclk, reset_n, reg_wr, reg_rd, mclk_pin, bclk_pin, fclk_pin, stretch;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, e_flags;
  logic [3:0] serial_fmt;
  logic [9:0] unmute_level;
  aaces_pkg::aaces_fault_t fault_in;
  aaces_pkg::aaces_sysctl_t sys_ctrl;
  int per_frame, n_errors, n_checks, cyc;
  int pf [5] = '{64, 128, 160, 256, 384};
  logic [7:0] st [5];

  // value is arbitrary
  aaces_regs #(.REV_ID(8'h3c)) u_dut (
    .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .aud_mclk_pin(mclk_pin),
    .aud_bclk_pin(bclk_pin), .aud_fclk_pin(fclk_pin),
    .fault_in(fault_in), .sys_ctrl(sys_ctrl), .serial_fmt(serial_fmt),
    .unmute_level(unmute_level)
  );
  aaces_clk_src u_src (.per_frame(per_frame), .stretch(stretch),
    .mclk_pin(mclk_pin), .bclk_pin(bclk_pin), .fclk_pin(fclk_pin));
  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #10 d = reg_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    check(d, exp);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // longest run is about 32k cycles of frames
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 50000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    stretch = 1'b0;
    fault_in = '0;
    per_frame = 64;
    e_flags = 8'h00;
    st[0] = {aaces_pkg::RATE_48K, aaces_pkg::RATIO_64, 2'b00};
    st[1] = {aaces_pkg::RATE_24K, aaces_pkg::RATIO_BAD, 2'b00};
    st[2] = {aaces_pkg::RATE_16K, aaces_pkg::RATIO_BAD, 2'b00};
    st[3] = {aaces_pkg::RATE_12K, aaces_pkg::RATIO_256, 2'b00};
    st[4] = {aaces_pkg::RATE_8K, aaces_pkg::RATIO_384, 2'b00};
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    rdc(8'h00, 8'h6c);
    rdc(8'h01, 8'h3c);
    rdc(8'h02, 8'h00);
    rdc(8'h03, 8'h80);
    rdc(8'h04, 8'h05);
    rdc(8'h09, 8'h00);
    wr(8'h00, 8'hff);
    wr(8'h01, 8'h00);
    rdc(8'h00, 8'h6c);
    rdc(8'h01, 8'h3c);
    $display("reset and read-only test done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h03, {k[0], 1'b1, k[1], 3'b111, k[1:0]});
      rdc(8'h03, {k[0], 1'b0, k[1], 3'b000, k[1:0]});
      check({4'h0, sys_ctrl}, {4'h0, k[0], k[1], k[1:0]});
    end
    for (int f = 0; f < 9; f++) begin
      wr(8'h04, {4'ha, f[3:0]});
      rdc(8'h04, {4'h0, f[3:0]});
      check({4'h0, serial_fmt}, {4'h0, f[3:0]});
    end
    wr(8'h04, 8'h05);
    wr(8'h03, 8'h80);
    $display("control register test done");
    for (int i = 0; i < 5; i++) begin
      if (i == 4)
        wr(8'h03, 8'ha0);
      per_frame = pf[i];
      repeat (4) @(posedge fclk_pin);
      rd(8'h02);
      if (i > 0)
        check(d & 8'hb0, 8'hb0);
      wr(8'h02, 8'h00);
      repeat (3) @(posedge fclk_pin);
      rdc(8'h02, 8'h00);
      rdc(8'h00, st[i]);
      if (i > 0)
        check({7'h0, unmute_level == 10'h200}, {7'h0, i == 4});
    end
    @(posedge mclk);
    stretch <= 1'b1;
    repeat (2) @(posedge mclk);
    stretch <= 1'b0;
    repeat (3) @(posedge fclk_pin);
    rdc(8'h02, 8'h08);
    wr(8'h02, 8'h00);
    $display("clock detection test done");
    wr(8'h03, 8'h80);
    for (int j = 0; j < 3; j++) begin
      @(posedge mclk);
      fault_in <= aaces_pkg::aaces_fault_t'(3'b001 << j);
      @(posedge mclk);
      fault_in <= '0;
      e_flags = e_flags | ((j == 2) ? 8'h40 : 8'h02 << j);
      rdc(8'h02, e_flags);
    end
    wr(8'h02, 8'hff);
    rdc(8'h02, 8'h46);
    @(posedge mclk);
    fault_in <= aaces_pkg::aaces_fault_t'(3'b010);
    wr(8'h02, 8'h00);
    rdc(8'h02, 8'h04);
    @(posedge mclk);
    fault_in <= '0;
    wr(8'h02, 8'h00);
    rdc(8'h02, 8'h00);
    $display("sticky fault test done");
    close_out();
  end
endmodule

// *** verilog/aaces_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ns
module aaces_pin_sync (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic pin,
  output logic level,
  output logic rise
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic rise_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change is taken only once stages two and three agree
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      rise_reg <= 1'b0;
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
        rise_reg <= s3_reg & ~level_reg;
      end
    end
  end

  assign level = level_reg;
  assign rise = rise_reg;

endmodule

// *** verilog/aaces_pkg.sv ***
// package: register map, field layout, codes and timing of the clock/error block
package aaces_pkg;

  // register offsets
  localparam logic [7:0] ADDR_CLK_STATUS = 8'h00;
  localparam logic [7:0] ADDR_REV_ID = 8'h01;
  localparam logic [7:0] ADDR_ERR_FLAGS = 8'h02;
  localparam logic [7:0] ADDR_SYS_CTRL = 8'h03;
  localparam logic [7:0] ADDR_SER_FMT = 8'h04;

  // clock status field positions
  localparam int RATE_MSB = 7;
  localparam int RATE_LSB = 5;
  localparam int RATIO_MSB = 4;
  localparam int RATIO_LSB = 2;

  // error flag bit positions
  localparam int ERR_MCLK_BIT = 7;
  localparam int ERR_PLL_BIT = 6;
  localparam int ERR_BCLK_BIT = 5;
  localparam int ERR_FCLK_BIT = 4;
  localparam int ERR_SLIP_BIT = 3;
  localparam int ERR_CLIP_BIT = 2;
  localparam int ERR_PROT_BIT = 1;

  // system control bit positions
  localparam int SYS_DCBLOCK_BIT = 7;
  localparam int SYS_HARDUNMUTE_BIT = 5;
  localparam int SYS_DEEMPH_MSB = 1;
  localparam int SYS_DEEMPH_LSB = 0;

  // reset values
  localparam logic [7:0] CLK_STATUS_RST = 8'h6c;
  localparam logic [7:0] ERR_FLAGS_RST = 8'h00;
  localparam logic [7:0] SYS_CTRL_RST = 8'h80;
  localparam logic [3:0] SER_FMT_RST = 4'h5;

  // sample-rate class codes
  localparam logic [2:0] RATE_32K = 3'h0;
  localparam logic [2:0] RATE_48K = 3'h3;
  localparam logic [2:0] RATE_16K = 3'h4;
  localparam logic [2:0] RATE_24K = 3'h5;
  localparam logic [2:0] RATE_8K = 3'h6;
  localparam logic [2:0] RATE_12K = 3'h7;

  // master clock ratio codes
  localparam logic [2:0] RATIO_64 = 3'h0;
  localparam logic [2:0] RATIO_128 = 3'h1;
  localparam logic [2:0] RATIO_192 = 3'h2;
  localparam logic [2:0] RATIO_256 = 3'h3;
  localparam logic [2:0] RATIO_384 = 3'h4;
  localparam logic [2:0] RATIO_512 = 3'h5;
  localparam logic [2:0] RATIO_BAD = 3'h6;

  // frame period class bounds, in 10 MHz cycles (midpoints between rates)
  localparam logic [15:0] PER_MAX_48K = 16'h010e;
  localparam logic [15:0] PER_MAX_32K = 16'h016c;
  localparam logic [15:0] PER_MAX_24K = 16'h021b;
  localparam logic [15:0] PER_MAX_16K = 16'h02d9;
  localparam logic [15:0] PER_MAX_12K = 16'h0436;
  // master clock count class bounds per frame
  localparam logic [15:0] MCNT_MAX_64 = 16'h0060;
  localparam logic [15:0] MCNT_MAX_128 = 16'h00a0;
  localparam logic [15:0] MCNT_MAX_192 = 16'h00e0;
  localparam logic [15:0] MCNT_MAX_256 = 16'h0140;
  localparam logic [15:0] MCNT_MAX_384 = 16'h01c0;

  // timing
  localparam logic [15:0] PERIOD_TOL = 16'h0002;
  localparam logic [15:0] FRAME_TIMEOUT = 16'h0800;
  localparam logic [9:0] RAMP_STEPS = 10'h200;
  localparam logic [1:0] FRAMES_PER_STEP = 2'h3;

  typedef struct packed {
    logic dc_block_en;
    logic hard_unmute;
    logic [1:0] deemph;
  } aaces_sysctl_t;

  typedef struct packed {
    logic pll_fail;
    logic clip;
    logic protect;
  } aaces_fault_t;

endpackage

// *** verilog/aaces_regs.sv ***
// clock detection, sticky error flags and system control register bank
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
module aaces_regs #(
  // value is arbitrary
  parameter logic [7:0] REV_ID = 8'h5a
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic aud_mclk_pin,
  input wire logic aud_bclk_pin,
  input wire logic aud_fclk_pin,
  input wire aaces_pkg::aaces_fault_t fault_in,
  output aaces_pkg::aaces_sysctl_t sys_ctrl,
  output logic [3:0] serial_fmt,
  output logic [9:0] unmute_level
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  function automatic logic [15:0] abs_diff(input logic [15:0] a,
                                           input logic [15:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  function automatic logic [2:0] rate_class(input logic [15:0] per);
    if (per < aaces_pkg::PER_MAX_48K) begin
      rate_class = aaces_pkg::RATE_48K;
    end else if (per < aaces_pkg::PER_MAX_32K) begin
      rate_class = aaces_pkg::RATE_32K;
    end else if (per < aaces_pkg::PER_MAX_24K) begin
      rate_class = aaces_pkg::RATE_24K;
    end else if (per < aaces_pkg::PER_MAX_16K) begin
      rate_class = aaces_pkg::RATE_16K;
    end else if (per < aaces_pkg::PER_MAX_12K) begin
      rate_class = aaces_pkg::RATE_12K;
    end else begin
      rate_class = aaces_pkg::RATE_8K;
    end
  endfunction

  function automatic logic [2:0] ratio_class(input logic [15:0] cnt);
    if (cnt < aaces_pkg::MCNT_MAX_64) begin
      ratio_class = aaces_pkg::RATIO_64;
    end else if (cnt < aaces_pkg::MCNT_MAX_128) begin
      ratio_class = aaces_pkg::RATIO_128;
    end else if (cnt < aaces_pkg::MCNT_MAX_192) begin
      ratio_class = aaces_pkg::RATIO_192;
    end else if (cnt < aaces_pkg::MCNT_MAX_256) begin
      ratio_class = aaces_pkg::RATIO_256;
    end else if (cnt < aaces_pkg::MCNT_MAX_384) begin
      ratio_class = aaces_pkg::RATIO_384;
    end else begin
      ratio_class = aaces_pkg::RATIO_512;
    end
  endfunction

  // unsupported rate/ratio pairs report the reserved ratio code
  function automatic logic ratio_allowed(input logic [2:0] rate,
                                         input logic [2:0] ratio);
    case (ratio)
      aaces_pkg::RATIO_64, aaces_pkg::RATIO_128:
        ratio_allowed = (rate == aaces_pkg::RATE_48K);
      aaces_pkg::RATIO_192:
        ratio_allowed = (rate == aaces_pkg::RATE_48K) ||
                        (rate == aaces_pkg::RATE_32K);
      aaces_pkg::RATIO_256:
        ratio_allowed = (rate != aaces_pkg::RATE_8K);
      default: ratio_allowed = 1'b1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic m_rise;
  logic b_rise;
  logic f_rise;

  aaces_pin_sync u_sync_mclk (.mclk(mclk), .reset_n(reset_n),
    .pin(aud_mclk_pin), .level(), .rise(m_rise));

  aaces_pin_sync u_sync_bclk (.mclk(mclk), .reset_n(reset_n),
    .pin(aud_bclk_pin), .level(), .rise(b_rise));

  aaces_pin_sync u_sync_fclk (.mclk(mclk), .reset_n(reset_n),
    .pin(aud_fclk_pin), .level(), .rise(f_rise));

  ////////////////////////////////////////////////////////////////////////////
  // per-frame measurement

  logic [15:0] period_cnt_reg;
  logic [15:0] mclk_cnt_reg;
  logic [15:0] bclk_cnt_reg;
  logic [15:0] prev_period_reg;
  logic [15:0] prev_mclk_reg;
  logic [15:0] prev_bclk_reg;
  logic have_prev_reg;
  logic timeout_seen_reg;
  logic timeout_ev;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      period_cnt_reg <= 16'h0000;
      mclk_cnt_reg <= 16'h0000;
      bclk_cnt_reg <= 16'h0000;
    end else if (f_rise) begin
      period_cnt_reg <= 16'h0001;
      mclk_cnt_reg <= {15'h0000, m_rise};
      bclk_cnt_reg <= {15'h0000, b_rise};
    end else begin
      period_cnt_reg <= sat_inc(period_cnt_reg);
      if (m_rise) begin
        mclk_cnt_reg <= sat_inc(mclk_cnt_reg);
      end
      if (b_rise) begin
        bclk_cnt_reg <= sat_inc(bclk_cnt_reg);
      end
    end
  end

  // first edge after reset or a stall only arms the comparison
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prev_period_reg <= 16'h0000;
      prev_mclk_reg <= 16'h0000;
      prev_bclk_reg <= 16'h0000;
      have_prev_reg <= 1'b0;
    end else if (f_rise) begin
      prev_period_reg <= period_cnt_reg;
      prev_mclk_reg <= mclk_cnt_reg;
      prev_bclk_reg <= bclk_cnt_reg;
      have_prev_reg <= 1'b1;
    end else if (timeout_ev) begin
      have_prev_reg <= 1'b0;
    end
  end

  // a stopped frame clock counts once as a frame clock change
  assign timeout_ev = (period_cnt_reg == aaces_pkg::FRAME_TIMEOUT) &&
                      !timeout_seen_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timeout_seen_reg <= 1'b0;
    end else if (f_rise) begin
      timeout_seen_reg <= 1'b0;
    end else if (timeout_ev) begin
      timeout_seen_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error events

  logic [15:0] per_delta;
  logic cmp_ok;
  logic ev_mclk;
  logic ev_bclk;
  logic ev_fclk;
  logic ev_slip;
  logic clk_err_ev;

  assign per_delta = abs_diff(period_cnt_reg, prev_period_reg);
  assign cmp_ok = f_rise && have_prev_reg;
  // mclk count jitters by one edge against the sampling clock
  assign ev_mclk = cmp_ok &&
    (abs_diff(mclk_cnt_reg, prev_mclk_reg) > 16'h0001);
  assign ev_bclk = cmp_ok &&
    (abs_diff(bclk_cnt_reg, prev_bclk_reg) > 16'h0001);
  assign ev_fclk = (cmp_ok && per_delta > aaces_pkg::PERIOD_TOL) ||
                   timeout_ev;
  // small drift against the expected period is phase slip, not rate change
  assign ev_slip = cmp_ok && per_delta != 16'h0000 &&
                   per_delta <= aaces_pkg::PERIOD_TOL;
  assign clk_err_ev = ev_mclk | ev_bclk | ev_fclk | ev_slip;

  ////////////////////////////////////////////////////////////////////////////
  // detected clock status

  logic [7:0] clk_status_reg;
  logic [2:0] rate_now;
  logic [2:0] ratio_now;

  assign rate_now = rate_class(period_cnt_reg);
  assign ratio_now = ratio_class(mclk_cnt_reg);

  // updated only from measurement; bus writes never reach it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clk_status_reg <= aaces_pkg::CLK_STATUS_RST;
    end else if (cmp_ok && !ev_fclk) begin
      clk_status_reg[aaces_pkg::RATE_MSB:aaces_pkg::RATE_LSB] <=
        rate_now;
      clk_status_reg[aaces_pkg::RATIO_MSB:aaces_pkg::RATIO_LSB] <=
        ratio_allowed(rate_now, ratio_now) ? ratio_now :
        aaces_pkg::RATIO_BAD;
      clk_status_reg[1:0] <= 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky error flags

  logic [7:0] err_reg;
  logic [7:0] err_set;
  logic err_wr;

  always_comb begin
    err_set = 8'h00;
    err_set[aaces_pkg::ERR_MCLK_BIT] = ev_mclk;
    err_set[aaces_pkg::ERR_PLL_BIT] = fault_in.pll_fail;
    err_set[aaces_pkg::ERR_BCLK_BIT] = ev_bclk;
    err_set[aaces_pkg::ERR_FCLK_BIT] = ev_fclk;
    err_set[aaces_pkg::ERR_SLIP_BIT] = ev_slip;
    err_set[aaces_pkg::ERR_CLIP_BIT] = fault_in.clip;
    err_set[aaces_pkg::ERR_PROT_BIT] = fault_in.protect;
  end

  assign err_wr = reg_wr && (reg_addr == aaces_pkg::ADDR_ERR_FLAGS);

  // a zero written clears; a one written keeps; a new event always wins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      err_reg <= aaces_pkg::ERR_FLAGS_RST;
    end else if (err_wr) begin
      err_reg <= ((err_reg & reg_wdata) | err_set) & 8'hfe;
    end else begin
      err_reg <= (err_reg | err_set) & 8'hfe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software settings

  aaces_pkg::aaces_sysctl_t sysctl_reg;
  logic [3:0] ser_fmt_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sysctl_reg.dc_block_en <=
        aaces_pkg::SYS_CTRL_RST[aaces_pkg::SYS_DCBLOCK_BIT];
      sysctl_reg.hard_unmute <=
        aaces_pkg::SYS_CTRL_RST[aaces_pkg::SYS_HARDUNMUTE_BIT];
      sysctl_reg.deemph <= aaces_pkg::SYS_CTRL_RST[
        aaces_pkg::SYS_DEEMPH_MSB:aaces_pkg::SYS_DEEMPH_LSB];
    end else if (reg_wr && reg_addr == aaces_pkg::ADDR_SYS_CTRL) begin
      sysctl_reg.dc_block_en <=
        reg_wdata[aaces_pkg::SYS_DCBLOCK_BIT];
      sysctl_reg.hard_unmute <=
        reg_wdata[aaces_pkg::SYS_HARDUNMUTE_BIT];
      sysctl_reg.deemph <= reg_wdata[
        aaces_pkg::SYS_DEEMPH_MSB:aaces_pkg::SYS_DEEMPH_LSB];
    end
  end

  // reserved format codes are stored as written
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ser_fmt_reg <= aaces_pkg::SER_FMT_RST;
    end else if (reg_wr && reg_addr == aaces_pkg::ADDR_SER_FMT) begin
      ser_fmt_reg <= reg_wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unmute after clock error

  logic [9:0] level_reg;
  logic [1:0] step_div_reg;

  // one ramp step per four frames matches the documented 48 kHz ramp time
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      level_reg <= aaces_pkg::RAMP_STEPS;
      step_div_reg <= 2'h0;
    end else if (clk_err_ev) begin
      level_reg <= 10'h000;
      step_div_reg <= 2'h0;
    end else if (f_rise && level_reg != aaces_pkg::RAMP_STEPS) begin
      if (sysctl_reg.hard_unmute) begin
        level_reg <= aaces_pkg::RAMP_STEPS;
      end else if (step_div_reg == aaces_pkg::FRAMES_PER_STEP) begin
        step_div_reg <= 2'h0;
        level_reg <= level_reg + 10'h001;
      end else begin
        step_div_reg <= step_div_reg + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port

  logic [7:0] rdata_reg;

  // data stands only in the cycle after the read strobe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        aaces_pkg::ADDR_CLK_STATUS: rdata_reg <= clk_status_reg;
        aaces_pkg::ADDR_REV_ID: rdata_reg <= REV_ID;
        aaces_pkg::ADDR_ERR_FLAGS: rdata_reg <= err_reg;
        aaces_pkg::ADDR_SYS_CTRL:
          rdata_reg <= {sysctl_reg.dc_block_en, 1'b0,
                        sysctl_reg.hard_unmute, 3'h0, sysctl_reg.deemph};
        aaces_pkg::ADDR_SER_FMT: rdata_reg <= {4'h0, ser_fmt_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;
  assign sys_ctrl = sysctl_reg;
  assign serial_fmt = ser_fmt_reg;
  assign unmute_level = level_reg;

endmodule
